/* File: core/axw_params.svh */
// Response, burst and lock encodings and reset values for the AXI3 write slave.
`ifndef AXW_PARAMS_SVH
`define AXW_PARAMS_SVH
`define AXW_RESP_OKAY    2'h0
`define AXW_RESP_EXOKAY  2'h1
`define AXW_RESP_SLVERR  2'h2
`define AXW_RESP_DECERR  2'h3
`define AXW_BURST_FIXED  2'h0
`define AXW_BURST_INCR   2'h1
`define AXW_BURST_WRAP   2'h2
`define AXW_LOCK_EXCL    2'h1
`define AXW_ADDR_RESET   32'h0000_0000
`define AXW_ID_RESET     4'h0
`define AXW_LEN_RESET    4'h0
`endif

/* File: core/axw_pkg.sv */
// Types shared by the AXI3 write slave modules.
package axw_pkg;
	typedef enum logic [2:0] {
		AXW_ADDR = 3'b001,
		AXW_DATA = 3'b010,
		AXW_RESP = 3'b100
	} axw_state_e;
	typedef logic [3:0]  axw_id_t;
	typedef logic [31:0] axw_addr_t;
	typedef logic [31:0] axw_data_t;
	typedef logic [3:0]  axw_strb_t;
	typedef logic [1:0]  axw_resp_t;
endpackage

/* File: core/axw_beat_if.sv */
// Beat carrier between the channel engine and the address stepper.
`timescale 1ns/1ns
`default_nettype none
interface axw_beat_if;
	import axw_pkg::*;
	logic      load;
	logic      step;
	axw_addr_t start;
	logic [2:0] size;
	logic [1:0] burst;
	logic [3:0] len;
	axw_addr_t addr;
	modport eng (output load, output step, output start, output size, output burst,
		output len, input addr);
	modport stp (input load, input step, input start, input size, input burst,
		input len, output addr);
endinterface
`default_nettype wire

/* File: core/axw_addr_step.sv */
// Beat address generator for fixed, incrementing and wrapping bursts.
`timescale 1ns/1ns
`default_nettype none
`include "axw_params.svh"
module axw_addr_step (
	input  wire logic clock,
	input  wire logic reset,
	axw_beat_if.stp   bt
);
	import axw_pkg::*;
	axw_addr_t addr_q;
	axw_addr_t addr_d;
	logic [2:0] size_q;
	logic [2:0] size_d;
	logic [1:0] burst_q;
	logic [1:0] burst_d;
	logic [3:0] len_q;
	logic [3:0] len_d;
	axw_addr_t inc;
	axw_addr_t wmask;
	always_comb begin
		addr_d = addr_q;
		size_d = size_q;
		burst_d = burst_q;
		len_d = len_q;
		inc = 32'h0000_0001 << size_q;
		wmask = ({28'h000_0000, len_q} + 32'h0000_0001) * inc - 32'h0000_0001;
		if (bt.load) begin
			addr_d = bt.start;
			size_d = bt.size;
			burst_d = bt.burst;
			len_d = bt.len;
		end else if (bt.step) begin
			// Address of later beats is derived here, never taken from the bus.
			if (burst_q == `AXW_BURST_INCR) begin
				addr_d = (addr_q & ~(inc - 32'h0000_0001)) + inc;
			end else if (burst_q == `AXW_BURST_WRAP) begin
				addr_d = (addr_q & ~wmask) | ((addr_q + inc) & wmask);
			end
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			addr_q <= `AXW_ADDR_RESET;
			size_q <= 3'h0;
			burst_q <= 2'h0;
			len_q <= `AXW_LEN_RESET;
		end else begin
			addr_q <= addr_d;
			size_q <= size_d;
			burst_q <= burst_d;
			len_q <= len_d;
		end
	end
	assign bt.addr = addr_q;
endmodule
`default_nettype wire

/* File: core/axw_slave.sv */
// AXI3 write channel slave that hands accepted beats to user logic.
`timescale 1ns/1ns
`default_nettype none
`include "axw_params.svh"
module axw_slave (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire axw_pkg::axw_id_t   awid,
	input  wire axw_pkg::axw_addr_t awaddr,
	input  wire logic [3:0]       awlen,
	input  wire logic [2:0]       awsize,
	input  wire logic [1:0]       awburst,
	input  wire logic [1:0]       awlock,
	input  wire logic [3:0]       awcache,
	input  wire logic [2:0]       awprot,
	input  wire logic             awvalid,
	output logic                  awready,
	input  wire axw_pkg::axw_id_t   wid,
	input  wire axw_pkg::axw_data_t wdata,
	input  wire axw_pkg::axw_strb_t wstrb,
	input  wire logic             wlast,
	input  wire logic             wvalid,
	output logic                  wready,
	output axw_pkg::axw_id_t        bid,
	output axw_pkg::axw_resp_t      bresp,
	output logic                  bvalid,
	input  wire logic             bready,
	output logic                  user_we,
	output axw_pkg::axw_addr_t      user_addr,
	output axw_pkg::axw_data_t      user_data,
	output axw_pkg::axw_strb_t      user_strb,
	output logic [3:0]            user_cache,
	output logic [2:0]            user_prot
);
	import axw_pkg::*;
	axw_beat_if bt ();
	axw_addr_step u_step (
		.clock (clock),
		.reset (reset),
		.bt    (bt)
	);
	axw_state_e state_q;
	axw_state_e state_d;
	axw_id_t    id_q;
	axw_id_t    id_d;
	logic [3:0] left_q;
	logic [3:0] left_d;
	axw_resp_t  resp_q;
	axw_resp_t  resp_d;
	logic [3:0] cache_q;
	logic [3:0] cache_d;
	logic [2:0] prot_q;
	logic [2:0] prot_d;
	logic       we_q;
	logic       we_d;
	axw_addr_t  uaddr_q;
	axw_addr_t  uaddr_d;
	axw_data_t  udata_q;
	axw_data_t  udata_d;
	axw_strb_t  ustrb_q;
	axw_strb_t  ustrb_d;
	logic       aw_hs;
	logic       w_hs;
	logic       b_hs;
	// Handshakes complete only where valid and ready are both high.
	assign aw_hs = awvalid && (state_q == AXW_ADDR);
	assign w_hs = wvalid && (state_q == AXW_DATA);
	assign b_hs = bready && (state_q == AXW_RESP);
	assign bt.load = aw_hs;
	assign bt.step = w_hs;
	assign bt.start = awaddr;
	assign bt.size = awsize;
	assign bt.burst = awburst;
	assign bt.len = awlen;
	always_comb begin
		state_d = state_q;
		id_d = id_q;
		left_d = left_q;
		resp_d = resp_q;
		cache_d = cache_q;
		prot_d = prot_q;
		we_d = 1'b0;
		uaddr_d = uaddr_q;
		udata_d = udata_q;
		ustrb_d = ustrb_q;
		case (state_q)
			AXW_ADDR: begin
				if (aw_hs) begin
					id_d = awid;
					left_d = awlen;
					cache_d = awcache;
					prot_d = awprot;
					// No exclusive monitor is kept, so exclusive writes get a normal OKAY.
					resp_d = `AXW_RESP_OKAY;
					state_d = AXW_DATA;
				end
			end
			AXW_DATA: begin
				if (w_hs) begin
					we_d = 1'b1;
					uaddr_d = bt.addr;
					udata_d = wdata;
					ustrb_d = wstrb;
					// A stray ID or a misplaced last flag marks the burst as a slave error.
					if ((wid != id_q) || (wlast != (left_q == 4'h0))) begin
						resp_d = `AXW_RESP_SLVERR;
					end
					left_d = left_q - 4'h1;
					// The response waits for the final beat.
					if (left_q == 4'h0) begin
						state_d = AXW_RESP;
					end
				end
			end
			AXW_RESP: begin
				if (b_hs) begin
					state_d = AXW_ADDR;
				end
			end
			default: begin
				state_d = AXW_ADDR;
			end
		endcase
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= AXW_ADDR;
			id_q <= `AXW_ID_RESET;
			left_q <= `AXW_LEN_RESET;
			resp_q <= `AXW_RESP_OKAY;
			cache_q <= 4'h0;
			prot_q <= 3'h0;
			we_q <= 1'b0;
			uaddr_q <= `AXW_ADDR_RESET;
			udata_q <= 32'h0000_0000;
			ustrb_q <= 4'h0;
		end else begin
			state_q <= state_d;
			id_q <= id_d;
			left_q <= left_d;
			resp_q <= resp_d;
			cache_q <= cache_d;
			prot_q <= prot_d;
			we_q <= we_d;
			uaddr_q <= uaddr_d;
			udata_q <= udata_d;
			ustrb_q <= ustrb_d;
		end
	end
	// Ready and valid are decoded straight from one-hot state flops.
	assign awready = state_q[0];
	assign wready = state_q[1];
	assign bvalid = state_q[2];
	assign bid = id_q;
	assign bresp = resp_q;
	assign user_we = we_q;
	assign user_addr = uaddr_q;
	assign user_data = udata_q;
	assign user_strb = ustrb_q;
	assign user_cache = cache_q;
	assign user_prot = prot_q;
	AST_ONE_READY: assert property (@(posedge clock) disable iff (reset)
		$onehot({awready, wready, bvalid}))
		else $error("more than one channel active");
	AST_ADDR_TO_DATA: assert property (@(posedge clock) disable iff (reset)
		(awvalid && awready) |=> (wready && !awready))
		else $error("address accept did not open data phase");
	AST_BID_MATCH: assert property (@(posedge clock) disable iff (reset)
		(awvalid && awready) |=> (bid == $past(awid)))
		else $error("response id differs from address id");
	AST_RESP_AFTER_LAST: assert property (@(posedge clock) disable iff (reset)
		$rose(bvalid) |-> $past(wvalid && wready))
		else $error("response without final beat");
	AST_SINGLE_BEAT: assert property (@(posedge clock) disable iff (reset)
		(awvalid && awready && awlen == 4'h0) ##1 (wvalid && wready) |=> bvalid)
		else $error("single beat burst gave no response");
	AST_BVALID_HOLD: assert property (@(posedge clock) disable iff (reset)
		(bvalid && !bready) |=> (bvalid && $stable(bid) && $stable(bresp)))
		else $error("response dropped before ready");
	AST_BAD_ID_ERR: assert property (@(posedge clock) disable iff (reset)
		(wvalid && wready && wid != bid) |-> ##[1:32] (bvalid && bresp == `AXW_RESP_SLVERR))
		else $error("mismatched data id not reported");
	AST_USER_WRITE: assert property (@(posedge clock) disable iff (reset)
		(wvalid && wready) |=> (user_we && user_data == $past(wdata)
			&& user_strb == $past(wstrb)))
		else $error("accepted beat not passed to user");
	AST_INCR_STEP: assert property (@(posedge clock) disable iff (reset)
		(awvalid && awready && awburst == `AXW_BURST_INCR && awsize == 3'h2
			&& awaddr[1:0] == 2'h0) ##1 (wvalid && wready) ##1 (wvalid && wready)
			|=> (user_addr == $past(awaddr, 3) + 32'h0000_0004))
		else $error("incrementing step wrong");
	COV_SINGLE: cover property (@(posedge clock) disable iff (reset)
		(awvalid && awready && awlen == 4'h0) ##1 (wvalid && wready) ##1 (bvalid && bready));
	COV_BURST4: cover property (@(posedge clock) disable iff (reset)
		(awvalid && awready && awlen == 4'h3) ##[4:20] (bvalid && bready));
	COV_BSTALL: cover property (@(posedge clock) disable iff (reset)
		(bvalid && !bready) ##1 (bvalid && bready));
	COV_WRAP: cover property (@(posedge clock) disable iff (reset)
		(awvalid && awready && awburst == `AXW_BURST_WRAP));
endmodule
`default_nettype wire

/* File: sim/axw_master.sv */
// AXI3 write master model that also notes the results it expects.
`timescale 1ns/1ns
`default_nettype none
`include "axw_params.svh"
module axw_master (
	input  wire logic          clock,
	input  wire logic          awready,
	input  wire logic          wready,
	input  wire logic          bvalid,
	output axw_pkg::axw_id_t   awid,
	output axw_pkg::axw_addr_t awaddr,
	output logic [3:0]         awlen,
	output logic [2:0]         awsize,
	output logic [1:0]         awburst,
	output logic [1:0]         awlock,
	output logic [3:0]         awcache,
	output logic [2:0]         awprot,
	output logic               awvalid,
	output axw_pkg::axw_id_t   wid,
	output axw_pkg::axw_data_t wdata,
	output axw_pkg::axw_strb_t wstrb,
	output logic               wlast,
	output logic               wvalid,
	output logic               bready
);
	import axw_pkg::*;
	logic [31:0] seed = 32'h0001_0956;
	logic [74:0] beat_q[$];
	logic [5:0]  resp_q[$];
	int          stuck = 0;
	initial begin
		{awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awvalid} = '0;
		{wid, wdata, wstrb, wlast, wvalid, bready} = '0;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Ready is looked at mid-cycle, so a request drops only after the edge that took it.
	task automatic hold(input int ch);
		int   n;
		logic r;
		n = 0;
		r = 1'b0;
		while (r !== 1'b1 && n < 60) begin
			@(negedge clock);
			r = ch == 0 ? awready : ch == 1 ? wready : bvalid;
			n++;
			@(posedge clock);
		end
		if (r !== 1'b1)
			stuck++;
	endtask
	// Beat 0 is offered with the address, so data arriving early is exercised too.
	task automatic burst(input logic [1:0] bt, input int err);
		logic [31:0] r, a, tot, d;
		logic [3:0]  len, id;
		logic [2:0]  sz;
		int          n;
		r = rnd();
		sz = r[1:0] == 2'h3 ? 3'h2 : {1'b0, r[1:0]};
		len = bt == `AXW_BURST_WRAP ? (4'h2 << r[3:2]) - 4'h1 : r[7:4];
		id = r[11:8];
		a = rnd() & ~((32'h1 << sz) - 32'h1);
		tot = ({28'h0, len} + 32'h1) << sz;
		awid <= id;
		awaddr <= a;
		awlen <= len;
		awsize <= sz;
		awburst <= bt;
		awlock <= {1'b0, r[12]};
		awcache <= r[16:13];
		awprot <= r[19:17];
		awvalid <= 1'b1;
		for (n = 0; n <= int'(len); n++) begin
			d = rnd();
			wid <= err == 1 && n == 0 ? id ^ 4'h1 : id;
			wdata <= d;
			wstrb <= d[31:28];
			wlast <= (n == int'(len)) ^ (err == 2 && n == 0);
			wvalid <= 1'b1;
			beat_q.push_back({bt == `AXW_BURST_INCR ? a + (n << sz) :
				bt == `AXW_BURST_WRAP ? (a & ~(tot - 1)) | ((a + (n << sz)) & (tot - 1)) : a,
				d, d[31:28], r[16:13], r[19:17]});
			if (n == 0) begin
				hold(0);
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			hold(1);
			if (d[0] && n < int'(len)) begin
				wvalid <= 1'b0;
				wdata <= ~d;
				@(posedge clock);
			end
		end
		wvalid <= 1'b0;
		wdata <= ~d;
		resp_q.push_back({id, err != 0 ? `AXW_RESP_SLVERR : `AXW_RESP_OKAY});
		repeat (r[22:21]) @(posedge clock);
		bready <= 1'b1;
		hold(2);
		bready <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: sim/axw_slave_bench.sv */
// Self-checking bench for the AXI3 write slave.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module axw_slave_bench;
	import axw_pkg::*;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        awvalid, awready, wlast, wvalid, wready, bvalid, bready, user_we;
	axw_id_t     awid, wid, bid;
	axw_addr_t   awaddr, user_addr;
	axw_data_t   wdata, user_data;
	axw_strb_t   wstrb, user_strb;
	axw_resp_t   bresp;
	logic [3:0]  awlen, awcache, user_cache;
	logic [2:0]  awsize, awprot, user_prot;
	logic [1:0]  awburst, awlock;
	int          failures = 0;
	int          compares = 0;
	int          t;
	logic [74:0] eb;
	logic [5:0]  er;
	always #25 clock = ~clock;
	axw_slave dut_u (.clock, .reset, .awid, .awaddr, .awlen, .awsize, .awburst, .awlock,
		.awcache, .awprot, .awvalid, .awready, .wid, .wdata, .wstrb, .wlast, .wvalid,
		.wready, .bid, .bresp, .bvalid, .bready, .user_we, .user_addr, .user_data,
		.user_strb, .user_cache, .user_prot);
	axw_master m_u (.clock, .awready, .wready, .bvalid, .awid, .awaddr, .awlen, .awsize,
		.awburst, .awlock, .awcache, .awprot, .awvalid, .wid, .wdata, .wstrb, .wlast,
		.wvalid, .bready);
	task automatic summarize();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Outputs are read mid-cycle, where every registered value has settled.
	always @(negedge clock) begin
		if (!reset && wready === 1'b1)
			`CHK(awready, 1'b0)
		if (user_we === 1'b1) begin
			eb = m_u.beat_q.size() > 0 ? m_u.beat_q.pop_front() : '1;
			`CHK({user_addr, user_data, user_strb, user_cache, user_prot}, eb)
		end
		if (bvalid === 1'b1 && bready === 1'b1) begin
			er = m_u.resp_q.size() > 0 ? m_u.resp_q.pop_front() : '1;
			`CHK({bid, bresp, m_u.beat_q.size()}, {er, 32'd0})
		end
	end
	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		`CHK({awready, wready, bvalid, user_we}, 4'b1000)
		@(posedge clock);
		for (t = 0; t < 12; t++) begin
			m_u.burst(t[1:0], t % 3);
			m_u.burst(t[1:0], 0);
			$display("test %0d burst type %0d done", t, t % 4);
			// A handshake that never completed ends the loop once this test's two bursts are done.
			if (m_u.stuck != 0)
				break;
		end
		repeat (4) @(posedge clock);
		`CHK(m_u.stuck, 0)
		`CHK(m_u.beat_q.size() + m_u.resp_q.size(), 0)
		summarize();
	end
endmodule
`default_nettype wire
